// file: inc/irq_consts.svh
// register indices, field positions, reset values and source numbers of the interrupt control block
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

// register indices; byte address on the bus is four times the index
`define IDX_POL_LOW 8'hA4
`define IDX_POL_HIGH 8'hA5
`define IDX_FLAG_B 8'hA6
`define IDX_POL_THIRD 8'hA7
`define IDX_EN_A 8'hA8
`define IDX_EN_B 8'hA9
`define IDX_EN_C 8'hAA
`define IDX_EN_D 8'hAB
`define IDX_PRIO_LOW 8'hB8
`define IDX_FLAG_A 8'hC0
`define IDX_EVT_STATUS 8'hE0
`define IDX_EVT_MASK 8'hE1
`define IDX_PRIO_HIGH 8'hF8

// reset value and implemented-bit masks
`define REG_RESET 8'h00
`define MASK_SIX 8'h3F
`define MASK_EN_A 8'hBF
`define MASK_FLAG_B 8'hCF
`define MASK_EVT 8'h1F

// field positions
`define GLOBAL_EN_BIT 7
`define T0_OVF_BIT 7
`define T0_MATCH_BIT 6
`define FLAG_B_LINE8 0
`define FLAG_B_LINE10 1
`define FLAG_B_LINE11 2
`define FLAG_B_LINE12 3

// event status bits
`define EVT_EXT_LOW 0
`define EVT_EXT_HIGH 1
`define EVT_T0_OVF 2
`define EVT_T0_MATCH 3
`define EVT_ACK 4

// source numbers, lower number wins a tie
`define SRC_EXT10 5'h00
`define SRC_EXT11 5'h01
`define SRC_EXT0_7 5'h05
`define SRC_EXT8 5'h06
`define SRC_EXT12 5'h0B
`define SRC_T0_OVF 5'h0C
`define SRC_T0_MATCH 5'h0D

`endif

// file: inc/irq_pkg.sv
// types shared by the interrupt control block
package irq_pkg;
	typedef logic [7:0] reg8_t;
	typedef logic [4:0] src_idx_t;
	typedef logic [1:0] level_t;
	typedef enum logic [1:0] {EDGE_NONE, EDGE_RISE, EDGE_FALL, EDGE_BOTH} edge_mode_t;
endpackage

// file: rtl/irq_enable_priority_extint.sv
// interrupt enable, group priority and external edge flag block with apb register access
//
// Summary of operation
// - the second enable register holds, bit 5 to bit 0, enables for ext line 12, serial 0 tx, rx, two-wire, usart tx and ext line 8; bits 7:6 unused, reset zero.
// - the third enable register holds, bit 5 to 0, active-high enables for timer 4/5, 3, 2, 1, 0 match and timer 0 overflow.
// - the fourth enable register enables interval timer at bit 4, watchdog at 3, watch timer at 2, usart rx at 1 and converter at 0.
// - each group level is the pair {high-bits register bit, low-bits register bit}, 00 lowest to 11 highest; both six bits wide, reset zero.
// - bit n of the first external flag register sets on an edge of line n (0..7) and only a software write of zero clears it.
// - each line has a two-bit field: 00 off, 01 rising, 10 falling, 11 both edges.
// - the low polarity register holds fields for lines 3, 2, 1, 0 from the top pair down, reset zero.
// - the high polarity register holds fields for lines 7, 6, 5, 4 from the top pair down, reset zero.
// - the third polarity register holds fields for lines 12, 11, 10, 8 in pairs 7:6, 5:4, 3:2, 1:0, reset zero.
// - bit 7 of the second flag register sets on timer 0 overflow, clears by writing zero or by acknowledge; writing one does nothing.
// - bit 6 of the second flag register sets on timer 0 match, clears by writing zero or by acknowledge; writing one does nothing.
// - bits 3:0 of the second flag register flag lines 12, 11, 10, 8 and clear by writing zero or by acknowledge; writing one does nothing.
// - a maskable interrupt is taken only when the global enable (bit 7 of the first enable register) and its own enable are one.
// - the 24 sources form six priority groups of four, each group at the level set by its bit pair.
// - among pending requests of equal level the lower-numbered source is served first.
`timescale 1ns/1ps
`include "irq_consts.svh"

module irq_enable_priority_extint #(
	parameter int SRC_COUNT = 24,
	parameter int GROUP_COUNT = 6,
	parameter int ADDR_WIDTH = 12
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [7:0] ext_line_in,
	input wire logic [3:0] ext_line_hi_in,
	input wire logic timer0_overflow_evt,
	input wire logic timer0_match_evt,
	input wire logic [SRC_COUNT-1:0] periph_req,
	input wire logic int_ack,
	input wire irq_pkg::src_idx_t ack_src,
	output logic irq_req,
	output irq_pkg::src_idx_t irq_src,
	output irq_pkg::level_t irq_level,
	output logic evt_irq
);
	import irq_pkg::*;

	// ----------------------------------------
	// elaboration checks
	// ----------------------------------------
	if (SRC_COUNT != 24 || GROUP_COUNT != 6) begin : g_bad_count
		$error("source and group counts are fixed by the register layout");
	end
	if (ADDR_WIDTH < 10) begin : g_bad_addr
		$error("address too narrow for the register indices");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg8_t pol_low;
	reg8_t pol_high;
	reg8_t pol_third;
	reg8_t en_a;
	reg8_t en_b;
	reg8_t en_c;
	reg8_t en_d;
	reg8_t prio_low;
	reg8_t prio_high;
	reg8_t ext_line_pending;
	reg8_t flag_b;
	reg8_t evt_status;
	reg8_t evt_mask;
	logic [7:0] line_prev;
	logic [3:0] line_hi_prev;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
		edge_mode_t mode;
		logic hit;
		mode = edge_mode_t'(sel);
		case (mode)
			EDGE_RISE: hit = !prev && cur;
			EDGE_FALL: hit = prev && !cur;
			EDGE_BOTH: hit = prev != cur;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	function automatic level_t src_level(input int idx, input reg8_t hi, input reg8_t lo);
		int grp;
		grp = idx % GROUP_COUNT;
		return {hi[grp], lo[grp]};
	endfunction

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	logic [7:0] idx;
	logic idx_ok;
	logic acc_done;
	logic wr_en;
	logic rd_en;
	logic full_lane;
	reg8_t wbyte;
	reg8_t rbyte;
	logic mapped;

	assign idx = paddr[9:2];
	assign idx_ok = (ADDR_WIDTH == 10) ? 1'b1 : (paddr[ADDR_WIDTH-1:10] == '0);
	assign acc_done = psel && penable && pready;
	// only byte lane 0 carries data; a write without it is ignored
	assign full_lane = pstrb[0];
	assign wr_en = acc_done && pwrite && mapped && full_lane;
	assign rd_en = acc_done && !pwrite && mapped;
	assign wbyte = pwdata[7:0];

	always_comb begin
		mapped = idx_ok;
		rbyte = `REG_RESET;
		case (idx)
			`IDX_POL_LOW: rbyte = pol_low;
			`IDX_POL_HIGH: rbyte = pol_high;
			`IDX_FLAG_B: rbyte = flag_b & `MASK_FLAG_B;
			`IDX_POL_THIRD: rbyte = pol_third;
			`IDX_EN_A: rbyte = en_a & `MASK_EN_A;
			`IDX_EN_B: rbyte = en_b & `MASK_SIX;
			`IDX_EN_C: rbyte = en_c & `MASK_SIX;
			`IDX_EN_D: rbyte = en_d & `MASK_SIX;
			`IDX_PRIO_LOW: rbyte = prio_low & `MASK_SIX;
			`IDX_PRIO_HIGH: rbyte = prio_high & `MASK_SIX;
			`IDX_FLAG_A: rbyte = ext_line_pending;
			`IDX_EVT_STATUS: rbyte = evt_status;
			`IDX_EVT_MASK: rbyte = evt_mask;
			default: mapped = 1'b0;
		endcase
	end

	// one wait state so that read data comes from a flop
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && penable && !pready;
			if (psel && penable && !pready) begin
				prdata <= (!pwrite && mapped) ? {24'h00_0000, rbyte} : 32'h0000_0000;
				pslverr <= !mapped;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// plain read/write registers
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			pol_low <= `REG_RESET;
			pol_high <= `REG_RESET;
			pol_third <= `REG_RESET;
		end else if (wr_en) begin
			if (idx == `IDX_POL_LOW) pol_low <= wbyte;
			if (idx == `IDX_POL_HIGH) pol_high <= wbyte;
			if (idx == `IDX_POL_THIRD) pol_third <= wbyte;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			en_a <= `REG_RESET;
			en_b <= `REG_RESET;
			en_c <= `REG_RESET;
			en_d <= `REG_RESET;
		end else if (wr_en) begin
			if (idx == `IDX_EN_A) en_a <= wbyte & `MASK_EN_A;
			if (idx == `IDX_EN_B) en_b <= wbyte & `MASK_SIX;
			if (idx == `IDX_EN_C) en_c <= wbyte & `MASK_SIX;
			if (idx == `IDX_EN_D) en_d <= wbyte & `MASK_SIX;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			prio_low <= `REG_RESET;
			prio_high <= `REG_RESET;
		end else if (wr_en) begin
			if (idx == `IDX_PRIO_LOW) prio_low <= wbyte & `MASK_SIX;
			if (idx == `IDX_PRIO_HIGH) prio_high <= wbyte & `MASK_SIX;
		end
	end

	// ----------------------------------------
	// edge detection
	// ----------------------------------------
	logic [7:0] hit_low;
	logic [3:0] hit_high;
	logic [15:0] pol_lo_all;

	assign pol_lo_all = {pol_high, pol_low};

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			hit_low[i] = edge_hit(pol_lo_all[2*i +: 2], line_prev[i], ext_line_in[i]);
		end
		for (int k = 0; k < 4; k++) begin
			hit_high[k] = edge_hit(pol_third[2*k +: 2], line_hi_prev[k], ext_line_hi_in[k]);
		end
	end

	// lines reset to low history, so a line held high at release reads as a rising edge only if enabled
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			line_prev <= 8'h00;
			line_hi_prev <= 4'h0;
		end else begin
			line_prev <= ext_line_in;
			line_hi_prev <= ext_line_hi_in;
		end
	end

	// ----------------------------------------
	// flag registers
	// ----------------------------------------
	reg8_t ack_clear;
	reg8_t keep_b;
	reg8_t keep_a;
	reg8_t set_b;

	always_comb begin
		ack_clear = 8'h00;
		if (int_ack) begin
			case (ack_src)
				`SRC_EXT10: ack_clear[`FLAG_B_LINE10] = 1'b1;
				`SRC_EXT11: ack_clear[`FLAG_B_LINE11] = 1'b1;
				`SRC_EXT8: ack_clear[`FLAG_B_LINE8] = 1'b1;
				`SRC_EXT12: ack_clear[`FLAG_B_LINE12] = 1'b1;
				`SRC_T0_OVF: ack_clear[`T0_OVF_BIT] = 1'b1;
				`SRC_T0_MATCH: ack_clear[`T0_MATCH_BIT] = 1'b1;
				default: ack_clear = 8'h00;
			endcase
		end
		// a written zero clears, a written one keeps
		keep_b = (wr_en && idx == `IDX_FLAG_B) ? (wbyte | ~`MASK_FLAG_B) : 8'hFF;
		keep_a = (wr_en && idx == `IDX_FLAG_A) ? wbyte : 8'hFF;
		set_b = {timer0_overflow_evt, timer0_match_evt, 2'b00, hit_high};
	end

	// set wins over any clear landing in the same cycle
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			flag_b <= `REG_RESET;
		end else begin
			flag_b <= ((flag_b & keep_b & ~ack_clear) | set_b) & `MASK_FLAG_B;
		end
	end

	// acknowledge never touches these: software must clear them
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ext_line_pending <= `REG_RESET;
		end else begin
			ext_line_pending <= (ext_line_pending & keep_a) | hit_low;
		end
	end

	// ----------------------------------------
	// request selection toward the core
	// ----------------------------------------
	logic [SRC_COUNT-1:0] req;
	logic [SRC_COUNT-1:0] en_all;
	logic [SRC_COUNT-1:0] pending;
	logic found;
	src_idx_t best_src;
	level_t best_lvl;

	always_comb begin
		req = periph_req;
		req[`SRC_EXT10] = flag_b[`FLAG_B_LINE10];
		req[`SRC_EXT11] = flag_b[`FLAG_B_LINE11];
		req[`SRC_EXT0_7] = |ext_line_pending;
		req[`SRC_EXT8] = flag_b[`FLAG_B_LINE8];
		req[`SRC_EXT12] = flag_b[`FLAG_B_LINE12];
		req[`SRC_T0_OVF] = flag_b[`T0_OVF_BIT];
		req[`SRC_T0_MATCH] = flag_b[`T0_MATCH_BIT];
		en_all = {en_d[5:0], en_c[5:0], en_b[5:0], en_a[5:0]};
		pending = req & en_all & {SRC_COUNT{en_a[`GLOBAL_EN_BIT]}};
		found = 1'b0;
		best_src = 5'h00;
		best_lvl = 2'b00;
		// ascending scan, strictly greater replaces, so ties keep the lower number
		for (int i = 0; i < SRC_COUNT; i++) begin
			if (pending[i] && (!found || src_level(i, prio_high, prio_low) > best_lvl)) begin
				found = 1'b1;
				best_src = src_idx_t'(i);
				best_lvl = src_level(i, prio_high, prio_low);
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			irq_req <= 1'b0;
			irq_src <= 5'h00;
			irq_level <= 2'b00;
		end else begin
			irq_req <= found;
			irq_src <= best_src;
			irq_level <= best_lvl;
		end
	end

	// ----------------------------------------
	// event status, mask and interrupt line
	// ----------------------------------------
	reg8_t evt_set;
	reg8_t evt_keep;

	always_comb begin
		evt_set = 8'h00;
		evt_set[`EVT_EXT_LOW] = |hit_low;
		evt_set[`EVT_EXT_HIGH] = |hit_high;
		evt_set[`EVT_T0_OVF] = timer0_overflow_evt;
		evt_set[`EVT_T0_MATCH] = timer0_match_evt;
		evt_set[`EVT_ACK] = int_ack;
		evt_keep = (rd_en && idx == `IDX_EVT_STATUS) ? 8'h00 : 8'hFF;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			evt_status <= `REG_RESET;
		end else begin
			evt_status <= ((evt_status & evt_keep) | evt_set) & `MASK_EVT;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			evt_mask <= `REG_RESET;
		end else if (wr_en && idx == `IDX_EVT_MASK) begin
			evt_mask <= wbyte & `MASK_EVT;
		end
	end

	// the line lags the status by one cycle so that it too comes from a flop
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			evt_irq <= 1'b0;
		end else begin
			evt_irq <= |(evt_status & evt_mask);
		end
	end

endmodule // irq_enable_priority_extint

// file: verif/irq_sva.sv
// concurrent checks on the interrupt control block ports
`timescale 1ns/1ps
module irq_sva #(
	parameter int ADDR_WIDTH = 12
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq_req,
	input wire irq_pkg::src_idx_t irq_src,
	input wire irq_pkg::level_t irq_level,
	input wire logic evt_irq
);
	import irq_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	AST_ONE_WAIT: assert property (psel && !penable |-> !pready ##1 !pready ##1 pready) else $error("bad wait");
	AST_RDY_ACCESS: assert property (pready |-> psel && penable) else $error("ready outside access");
	AST_RDY_PULSE: assert property (pready |=> !pready) else $error("ready held");
	AST_ERR_RDY: assert property (pslverr |-> pready) else $error("error without ready");
	AST_UNMAPPED: assert property (pready && paddr[ADDR_WIDTH-1:10] != '0 |-> pslverr && prdata == 32'h0) else $error("unmapped");
	AST_HIGH_ZERO: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper bits");
	AST_SRC_RANGE: assert property (irq_req |-> irq_src < 5'h18) else $error("source range");
	AST_IDLE_QUIET: assert property (!psel |=> !pready && !pslverr) else $error("answer when idle");
	cover property (pslverr);
	cover property (irq_req && irq_level == 2'h3);
	cover property (evt_irq);
endmodule // irq_sva
bind irq_enable_priority_extint irq_sva #(.ADDR_WIDTH(ADDR_WIDTH)) u_sva (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.irq_req(irq_req), .irq_src(irq_src), .irq_level(irq_level), .evt_irq(evt_irq));

// file: verif/cpu_ack_model.sv
// core side model: acknowledges the offered source
`timescale 1ns/1ps
module cpu_ack_model (
	input wire logic clk_sys,
	input wire logic auto_ack,
	input wire logic irq_req,
	input wire irq_pkg::src_idx_t irq_src,
	output logic int_ack,
	output irq_pkg::src_idx_t ack_src
);
	import irq_pkg::*;
	logic [1:0] gap = 2'h0;
	initial int_ack = 1'b0;
	initial ack_src = 5'h00;
	// waits three cycles so a flag cleared by the last ack is not acked twice
	always @(posedge clk_sys) begin
		if (auto_ack && irq_req && gap == 2'h3) begin
			int_ack <= 1'b1;
			ack_src <= irq_src;
			gap <= 2'h0;
		end else begin
			int_ack <= 1'b0;
			ack_src <= ~ack_src;
			if (auto_ack && irq_req) gap <= gap + 2'h1;
		end
	end
endmodule // cpu_ack_model

// file: verif/testbench.sv
// self-checking bench of the interrupt control block
`timescale 1ns/1ps
`include "irq_consts.svh"
module testbench;
	import irq_pkg::*;
	logic clk_sys = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, t0o = 0, t0m = 0, auto_ack = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, int_ack, irq_req, evt_irq, e;
	logic [7:0] ext_line_in = 8'h00;
	logic [3:0] ext_line_hi_in = 4'h0;
	src_idx_t ack_src, irq_src;
	level_t irq_level;
	int n_errors = 0, checks = 0, cyc = 0;
	logic [23:0] periph_req = 24'h00_0000;
	logic [7:0] ix [11] = '{8'hA4, 8'hA5, 8'hA6, 8'hA7, 8'hA8, 8'hA9, 8'hAA, 8'hAB, 8'hB8, 8'hC0, 8'hF8};
	logic [7:0] mk [11] = '{8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hBF, 8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'h00, 8'h3F};
	always #50 clk_sys = ~clk_sys;
	irq_enable_priority_extint DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_line_in(ext_line_in), .ext_line_hi_in(ext_line_hi_in),
		.timer0_overflow_evt(t0o), .timer0_match_evt(t0m), .periph_req(periph_req), .int_ack(int_ack),
		.ack_src(ack_src), .irq_req(irq_req), .irq_src(irq_src), .irq_level(irq_level), .evt_irq(evt_irq));
	cpu_ack_model core (.clk_sys(clk_sys), .auto_ack(auto_ack), .irq_req(irq_req), .irq_src(irq_src),
		.int_ack(int_ack), .ack_src(ack_src));
	task finish_test;
		$display("checks %0d mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_errors++;
			finish_test;
		end
	end
	task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, x, s);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task wr(input logic [7:0] i, input logic [7:0] d);
		apb(1'b1, {2'b00, i, 2'b00}, d);
	endtask
	task rd(input logic [7:0] i, input logic [7:0] x);
		apb(1'b0, {2'b00, i, 2'b00}, 8'h00);
		chk($sformatf("reg %h", i), r, {24'h0, x});
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task pulse(input logic o, input logic m);
		@(posedge clk_sys);
		{t0o, t0m} <= {o, m};
		@(posedge clk_sys);
		{t0o, t0m} <= 2'b00;
		tick(3);
	endtask
	task t_regs;
		for (int k = 0; k < 11; k++) begin
			rd(ix[k], 8'h00);
			wr(ix[k], 8'hFF);
			rd(ix[k], mk[k]);
			wr(ix[k], 8'h00);
		end
		apb(1'b0, 12'hC00, 8'h00);
		chk("unmapped error", {31'h0, e}, 32'h1);
		chk("unmapped data", r, 32'h0);
		$display("test regs done");
	endtask
	task t_edge;
		for (int m = 0; m < 4; m++) begin
			wr(`IDX_POL_LOW, m[7:0]);
			@(posedge clk_sys) ext_line_in[0] <= 1'b1;
			tick(2);
			rd(`IDX_FLAG_A, {7'h0, m[0]});
			wr(`IDX_FLAG_A, 8'h00);
			@(posedge clk_sys) ext_line_in[0] <= 1'b0;
			tick(2);
			rd(`IDX_FLAG_A, {7'h0, m[1]});
			wr(`IDX_FLAG_A, 8'h00);
		end
		wr(`IDX_POL_LOW, 8'h40);
		wr(`IDX_POL_HIGH, 8'h01);
		wr(`IDX_POL_THIRD, 8'h40);
		@(posedge clk_sys) {ext_line_in, ext_line_hi_in} <= {8'h18, 4'h8};
		tick(2);
		rd(`IDX_FLAG_A, 8'h18);
		rd(`IDX_FLAG_B, 8'h08);
		wr(`IDX_FLAG_B, 8'h00);
		rd(`IDX_FLAG_B, 8'h00);
		for (int k = 0; k < 4; k++) wr(ix[k], 8'h00);
		wr(`IDX_FLAG_A, 8'h00);
		{ext_line_in, ext_line_hi_in} <= 12'h000;
		$display("test edges done");
	endtask
	task t_prio;
		wr(`IDX_EN_A, 8'h80);
		wr(`IDX_EN_C, 8'h03);
		pulse(1'b1, 1'b1);
		rd(`IDX_FLAG_B, 8'hC0);
		chk("tie source", {27'h0, irq_src}, {27'h0, `SRC_T0_OVF});
		wr(`IDX_PRIO_HIGH, 8'h02);
		wr(`IDX_PRIO_LOW, 8'h02);
		tick(3);
		chk("level source", {27'h0, irq_src}, {27'h0, `SRC_T0_MATCH});
		chk("level", {30'h0, irq_level}, 32'h3);
		wr(`IDX_EN_A, 8'h00);
		tick(3);
		chk("global off", {31'h0, irq_req}, 32'h0);
		wr(`IDX_EN_A, 8'h80);
		auto_ack <= 1'b1;
		tick(24);
		chk("acked", {31'h0, irq_req}, 32'h0);
		rd(`IDX_FLAG_B, 8'h00);
		auto_ack <= 1'b0;
		wr(`IDX_PRIO_HIGH, 8'h00);
		wr(`IDX_PRIO_LOW, 8'h00);
		periph_req <= 24'h04_4000;
		wr(`IDX_EN_C, 8'h04);
		wr(`IDX_EN_D, 8'h01);
		tick(3);
		chk("peripheral tie", {27'h0, irq_src}, 32'hE);
		wr(`IDX_EN_C, 8'h00);
		tick(3);
		chk("converter source", {26'h0, irq_req, irq_src}, 32'h32);
		wr(`IDX_EN_D, 8'h00);
		periph_req <= 24'h00_0000;
		$display("test priority done");
	endtask
	task t_ext;
		wr(`IDX_POL_THIRD, 8'h44);
		wr(`IDX_EN_A, 8'h81);
		@(posedge clk_sys) ext_line_hi_in <= 4'h2;
		tick(3);
		chk("line10 source", {26'h0, irq_req, irq_src}, {26'h0, 1'b1, `SRC_EXT10});
		wr(`IDX_EN_A, 8'h80);
		wr(`IDX_EN_B, 8'h20);
		@(posedge clk_sys) ext_line_hi_in <= 4'hA;
		tick(3);
		chk("line12 source", {26'h0, irq_req, irq_src}, {26'h0, 1'b1, `SRC_EXT12});
		wr(`IDX_POL_THIRD, 8'h00);
		ext_line_hi_in <= 4'h0;
		wr(`IDX_EN_B, 8'h00);
		wr(`IDX_FLAG_B, 8'h00);
		$display("test lines done");
	endtask
	task t_evt;
		apb(1'b0, {2'b00, `IDX_EVT_STATUS, 2'b00}, 8'h00);
		wr(`IDX_EVT_MASK, 8'h04);
		pulse(1'b1, 1'b0);
		chk("evt raised", {31'h0, evt_irq}, 32'h1);
		rd(`IDX_EVT_STATUS, 8'h04);
		tick(3);
		chk("evt cleared", {31'h0, evt_irq}, 32'h0);
		wr(`IDX_EVT_MASK, 8'h00);
		pulse(1'b1, 1'b0);
		chk("evt masked", {31'h0, evt_irq}, 32'h0);
		wr(`IDX_FLAG_B, 8'hFF);
		rd(`IDX_FLAG_B, 8'h80);
		$display("test events done");
	endtask
	initial begin
		tick(20);
		sys_rst <= 1'b0;
		t_regs;
		t_edge;
		t_prio;
		t_ext;
		t_evt;
		finish_test;
	end
endmodule // testbench
